// ===== verilog/sae_defs.svh
`ifndef SAE_DEFS_SVH
`define SAE_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SAE_ADR_CMD      8'h00
`define SAE_ADR_WDATA    8'h04
`define SAE_ADR_MPR0     8'h08
`define SAE_ADR_MPR3     8'h14
`define SAE_ADR_DSPEED   8'h18
`define SAE_ADR_DPULSE   8'h1c
`define SAE_ADR_SPLIT1   8'h20
`define SAE_ADR_ISPEED   8'h24
`define SAE_ADR_ACCEL    8'h28
`define SAE_ADR_STATUS   8'h2c
`define SAE_ADR_STEP     8'h30

// ****************************************
// Command codes
// ****************************************
`define SAE_CMD_STEP     8'h15
`define SAE_CMD_PIN1     8'h21
`define SAE_CMD_PIN2     8'h22
`define SAE_CMD_CFG0     8'h26
`define SAE_CMD_CFG3     8'h29
`define SAE_CMD_EN_HI    4'h8
`define SAE_CMD_DIS_HI   4'h9

// ****************************************
// Field positions
// ****************************************
`define SAE_CFG_ACT_HI   8
`define SAE_CFG_ACT_LO   4
`define SAE_CFG_REP      15
`define SAE_PIN2_POL_HI  3
`define SAE_PIN2_PW_HI   6
`define SAE_PIN2_PW_LO   4
`define SAE_PIN_MODE_ON  2'h3

// ****************************************
// Reset values
// ****************************************
`define SAE_RST_WORD     32'h0000_0000
`define SAE_RST_CFG      16'h0000

// ****************************************
// Pulse widths
// ****************************************
`define SAE_CLK_MHZ      25
`define SAE_PW0_NS       125
`define SAE_PW1_NS       312
`define SAE_PW2_NS       1000
`define SAE_PW3_NS       4000
`define SAE_PW4_NS       16000
`define SAE_PW5_NS       64000
`define SAE_PW6_NS       256000
`define SAE_PW7_NS       1000000
`define SAE_NS2CYC(ns)   ((((ns) * `SAE_CLK_MHZ) + 999) / 1000)

`endif

// ===== verilog/sae_pkg.sv
package sae_pkg;

   typedef enum logic [4:0] {
      act_none       = 5'h00,
      act_load_speed = 5'h01,
      act_load_pulse = 5'h02,
      act_load_split = 5'h03,
      act_load_setd  = 5'h04,
      act_save_lp    = 5'h05,
      act_save_rp    = 5'h06,
      act_save_timer = 5'h07,
      act_save_setd  = 5'h08,
      act_pin_pulse  = 5'h09,
      act_start_rel  = 5'h0a,
      act_start_crel = 5'h0b,
      act_start_abs  = 5'h0c,
      act_start_pos  = 5'h0d,
      act_start_neg  = 5'h0e,
      act_rel_mpr    = 5'h0f,
      act_abs_mpr    = 5'h10,
      act_dec_stop   = 5'h11,
      act_inst_stop  = 5'h12,
      act_speed_inc  = 5'h13,
      act_speed_dec  = 5'h14,
      act_timer_go   = 5'h15,
      act_timer_halt = 5'h16,
      act_split_go   = 5'h17,
      act_split_end  = 5'h18
   } sae_action_type;

   typedef struct packed {
      logic             ack;
      logic [31:0]      rdata;
      logic [31:0]      write_data_reg;
      logic [3:0][31:0] multi_purpose_reg;
      logic [3:0][15:0] cfg;
      logic [3:0]       en;
      logic [3:0]       pend;
      logic [7:0]       pin_mode;
      logic [3:0]       pin_pol;
      logic [2:0]       pw_code;
      logic [31:0]      step;
      logic [31:0]      drive_speed;
      logic [31:0]      drive_pulse_number;
      logic [31:0]      split_pulse_data1;
      logic [31:0]      initial_speed;
      logic [31:0]      acceleration_value;
      logic [31:0]      load_data;
      logic [3:0][14:0] pin_cnt;
      logic [3:0]       pin_lvl;
      logic [3:0]       fired;
      logic [16:0]      strobe;
   } sae_state_type;

endpackage

// ===== verilog/sae_top.sv
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "sae_defs.svh"

module sae_top #(
   parameter int unsigned PW6_CYC = `SAE_NS2CYC(`SAE_PW6_NS),
   parameter int unsigned PW7_CYC = `SAE_NS2CYC(`SAE_PW7_NS)
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [3:0]  activation_i,
   input  wire logic [31:0] logical_position_counter_i,
   input  wire logic [31:0] real_position_counter_i,
   input  wire logic [31:0] current_timer_value_i,
   input  wire logic [31:0] current_drive_speed_i,
   input  wire logic [31:0] current_accel_value_i,
   input  wire logic        scurve_ramp_i,
   input  wire logic        interp_drive_i,
   output logic      [31:0] drive_speed_o,
   output logic      [31:0] drive_pulse_number_o,
   output logic      [31:0] split_pulse_data1_o,
   output logic      [31:0] initial_speed_o,
   output logic      [31:0] acceleration_value_o,
   output logic      [31:0] speed_step_o,
   output logic      [31:0] load_data_o,
   output logic             lp_load_o,
   output logic             rp_load_o,
   output logic             start_rel_o,
   output logic             start_cnt_rel_o,
   output logic             start_abs_o,
   output logic             start_pos_cont_o,
   output logic             start_neg_cont_o,
   output logic             dec_stop_o,
   output logic             inst_stop_o,
   output logic             speed_inc_o,
   output logic             speed_dec_o,
   output logic             timer_start_o,
   output logic             timer_stop_o,
   output logic             split_start_o,
   output logic             split_end_o,
   output logic [3:0]       sync_fired_o,
   output logic [3:0]       gp_io_pin_o,
   output logic [3:0]       gp_io_pin_oe_n_o
);
   import sae_pkg::*;

   sae_state_type  s;
   sae_state_type  next_s;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [31:0]    wmask;
      logic [31:0]    mpr;
      logic           wr;
      logic           hit;
      logic [1:0]     k;
      logic [14:0]    width;
      sae_action_type code;
      // ****************************************
      // Defaults
      // ****************************************
      wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wr     = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
      hit    = 1'b0;
      k      = 2'd0;
      mpr    = 32'h0000_0000;
      width  = 15'h0000;
      code   = act_none;
      next_s = s;
      next_s.strobe = '0;
      next_s.fired  = '0;
      next_s.ack    = wb_cyc_i & wb_stb_i & ~s.ack;

      // ****************************************
      // Shared width select
      // ****************************************
      case (s.pw_code)
         3'd0: width = 15'(`SAE_NS2CYC(`SAE_PW0_NS));
         3'd1: width = 15'(`SAE_NS2CYC(`SAE_PW1_NS));
         3'd2: width = 15'(`SAE_NS2CYC(`SAE_PW2_NS));
         3'd3: width = 15'(`SAE_NS2CYC(`SAE_PW3_NS));
         3'd4: width = 15'(`SAE_NS2CYC(`SAE_PW4_NS));
         3'd5: width = 15'(`SAE_NS2CYC(`SAE_PW5_NS));
         3'd6: width = 15'(PW6_CYC);
         default: width = 15'(PW7_CYC);
      endcase

      // ****************************************
      // Pulse timers
      // ****************************************
      for (int i = 0; i < 4; i++) begin
         if (s.pin_cnt[i] != 15'h0000) begin
            next_s.pin_cnt[i] = s.pin_cnt[i] - 15'h0001;
         end
      end

      // ****************************************
      // Bus writes and commands
      // ****************************************
      if (wr) begin
         case (wb_adr_i)
            `SAE_ADR_CMD: begin
               if (wb_dat_i[7:0] == `SAE_CMD_STEP) begin
                  next_s.step = s.write_data_reg;
               end else if (wb_dat_i[7:0] == `SAE_CMD_PIN1) begin
                  next_s.pin_mode = s.write_data_reg[7:0];
               end else if (wb_dat_i[7:0] == `SAE_CMD_PIN2) begin
                  next_s.pin_pol = s.write_data_reg[`SAE_PIN2_POL_HI:0];
                  next_s.pw_code =
                     s.write_data_reg[`SAE_PIN2_PW_HI:`SAE_PIN2_PW_LO];
               end else if (wb_dat_i[7:0] >= `SAE_CMD_CFG0 &&
                            wb_dat_i[7:0] <= `SAE_CMD_CFG3) begin
                  next_s.cfg[2'(wb_dat_i[7:0] - `SAE_CMD_CFG0)] =
                     s.write_data_reg[15:0];
               end else if (wb_dat_i[7:4] == `SAE_CMD_EN_HI) begin
                  next_s.en = s.en | wb_dat_i[3:0];
               end else if (wb_dat_i[7:4] == `SAE_CMD_DIS_HI) begin
                  next_s.en = s.en & ~wb_dat_i[3:0];
               end
            end
            `SAE_ADR_WDATA: begin
               next_s.write_data_reg = (s.write_data_reg & ~wmask) | (wb_dat_i & wmask);
            end
            `SAE_ADR_DPULSE: begin
               next_s.drive_pulse_number =
                  (s.drive_pulse_number & ~wmask) | (wb_dat_i & wmask);
            end
            default: begin
               if (wb_adr_i >= `SAE_ADR_MPR0 && wb_adr_i <= `SAE_ADR_MPR3 &&
                   wb_adr_i[1:0] == 2'h0) begin
                  next_s.multi_purpose_reg[wb_adr_i[3:2] - 2'd2] =
                     (s.multi_purpose_reg[wb_adr_i[3:2] - 2'd2] & ~wmask) |
                     (wb_dat_i & wmask);
               end
            end
         endcase
      end

      // ****************************************
      // Action service, lowest set first
      // ****************************************
      for (int i = 3; i >= 0; i--) begin
         if (s.pend[i]) begin
            hit = 1'b1;
            k   = 2'(i);
         end
      end
      mpr  = s.multi_purpose_reg[k];
      code = sae_action_type'(s.cfg[k][`SAE_CFG_ACT_HI:`SAE_CFG_ACT_LO]);
      if (hit) begin
         next_s.pend[k]  = 1'b0;
         next_s.fired[k] = 1'b1;
         case (code)
            act_load_speed: begin
               next_s.drive_speed = mpr;
            end
            act_load_pulse: begin
               next_s.drive_pulse_number = mpr;
            end
            act_load_split: begin
               next_s.split_pulse_data1 = mpr;
            end
            act_load_setd: begin
               case (k)
                  2'd0: begin
                     next_s.load_data = mpr;
                     next_s.strobe[0] = 1'b1;
                  end
                  2'd1: begin
                     next_s.load_data = mpr;
                     next_s.strobe[1] = 1'b1;
                  end
                  2'd2: next_s.initial_speed = mpr;
                  default: next_s.acceleration_value = mpr;
               endcase
            end
            act_save_lp: begin
               next_s.multi_purpose_reg[k] = logical_position_counter_i;
            end
            act_save_rp: begin
               next_s.multi_purpose_reg[k] = real_position_counter_i;
            end
            act_save_timer: begin
               next_s.multi_purpose_reg[k] = current_timer_value_i;
            end
            act_save_setd: begin
               if (k == 2'd0) begin
                  next_s.multi_purpose_reg[0] = current_drive_speed_i;
               end else if (k == 2'd1) begin
                  next_s.multi_purpose_reg[1] = current_accel_value_i;
               end
            end
            act_pin_pulse: begin
               if (s.pin_mode[2*k +: 2] == `SAE_PIN_MODE_ON) begin
                  next_s.pin_cnt[k] = width;
               end
            end
            act_start_rel: begin
               next_s.strobe[2] = 1'b1;
            end
            act_start_crel: begin
               next_s.strobe[3] = 1'b1;
            end
            act_start_abs: begin
               next_s.strobe[4] = 1'b1;
            end
            act_start_pos: begin
               next_s.strobe[5] = 1'b1;
            end
            act_start_neg: begin
               next_s.strobe[6] = 1'b1;
            end
            act_rel_mpr: begin
               next_s.drive_pulse_number = mpr;
               next_s.strobe[2] = 1'b1;
            end
            act_abs_mpr: begin
               next_s.drive_pulse_number = mpr;
               next_s.strobe[4] = 1'b1;
            end
            act_dec_stop: begin
               next_s.strobe[7] = 1'b1;
            end
            act_inst_stop: begin
               next_s.strobe[8] = 1'b1;
            end
            act_speed_inc: begin
               next_s.strobe[9] = ~(scurve_ramp_i | interp_drive_i);
            end
            act_speed_dec: begin
               next_s.strobe[10] = ~(scurve_ramp_i | interp_drive_i);
            end
            act_timer_go: begin
               next_s.strobe[11] = 1'b1;
            end
            act_timer_halt: begin
               next_s.strobe[12] = 1'b1;
            end
            act_split_go: begin
               next_s.strobe[13] = 1'b1;
            end
            act_split_end: begin
               next_s.strobe[14] = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // Activation capture; new activation wins over service clear
      // ****************************************
      for (int i = 0; i < 4; i++) begin
         if (activation_i[i] & s.en[i]) begin
            next_s.pend[i] = 1'b1;
            if (!s.cfg[i][`SAE_CFG_REP]) begin
               next_s.en[i] = 1'b0;
            end
         end
      end

      // ****************************************
      // Pin levels
      // ****************************************
      for (int i = 0; i < 4; i++) begin
         next_s.pin_lvl[i] = (next_s.pin_cnt[i] != 15'h0000) ^ next_s.pin_pol[i];
      end

      // ****************************************
      // Read data
      // ****************************************
      next_s.rdata = `SAE_RST_WORD;
      case (wb_adr_i)
         `SAE_ADR_WDATA:  next_s.rdata = s.write_data_reg;
         `SAE_ADR_DSPEED: next_s.rdata = s.drive_speed;
         `SAE_ADR_DPULSE: next_s.rdata = s.drive_pulse_number;
         `SAE_ADR_SPLIT1: next_s.rdata = s.split_pulse_data1;
         `SAE_ADR_ISPEED: next_s.rdata = s.initial_speed;
         `SAE_ADR_ACCEL:  next_s.rdata = s.acceleration_value;
         `SAE_ADR_STEP:   next_s.rdata = s.step;
         `SAE_ADR_STATUS: next_s.rdata = {20'h00000, s.pin_lvl ^ s.pin_pol, s.pend, s.en};
         default: begin
            if (wb_adr_i >= `SAE_ADR_MPR0 && wb_adr_i <= `SAE_ADR_MPR3 &&
                wb_adr_i[1:0] == 2'h0) begin
               next_s.rdata = s.multi_purpose_reg[wb_adr_i[3:2] - 2'd2];
            end
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s     <= '0;
         s.cfg <= {4{`SAE_RST_CFG}};
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_dat_o             = s.rdata;
   assign wb_ack_o             = s.ack;
   assign drive_speed_o        = s.drive_speed;
   assign drive_pulse_number_o = s.drive_pulse_number;
   assign split_pulse_data1_o  = s.split_pulse_data1;
   assign initial_speed_o      = s.initial_speed;
   assign acceleration_value_o = s.acceleration_value;
   assign speed_step_o         = s.step;
   assign load_data_o          = s.load_data;
   assign lp_load_o            = s.strobe[0];
   assign rp_load_o            = s.strobe[1];
   assign start_rel_o          = s.strobe[2];
   assign start_cnt_rel_o      = s.strobe[3];
   assign start_abs_o          = s.strobe[4];
   assign start_pos_cont_o     = s.strobe[5];
   assign start_neg_cont_o     = s.strobe[6];
   assign dec_stop_o           = s.strobe[7];
   assign inst_stop_o          = s.strobe[8];
   assign speed_inc_o          = s.strobe[9];
   assign speed_dec_o          = s.strobe[10];
   assign timer_start_o        = s.strobe[11];
   assign timer_stop_o         = s.strobe[12];
   assign split_start_o        = s.strobe[13];
   assign split_end_o          = s.strobe[14];
   assign sync_fired_o         = s.fired;
   assign gp_io_pin_o          = s.pin_lvl;

   // ****************************************
   // Pin output enables
   // ****************************************
   generate
      for (genvar g = 0; g < 4; g++) begin : g_oe
         assign gp_io_pin_oe_n_o[g] = ~(s.pin_mode[2*g +: 2] == `SAE_PIN_MODE_ON);
      end
   endgenerate

endmodule

// ===== sim/sae_props.sv
`timescale 1ns/10ps
module sae_props (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_ack_o,
   input  wire logic [3:0] activation_i,
   input  wire logic       scurve_ramp_i,
   input  wire logic       interp_drive_i,
   input  wire logic       speed_inc_o,
   input  wire logic       speed_dec_o,
   input  wire logic       dec_stop_o,
   input  wire logic       inst_stop_o,
   input  wire logic [3:0] sync_fired_o,
   input  wire logic [3:0] gp_io_pin_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ****************************************
   // Sequences and properties
   // ****************************************
   sequence s_req;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   sequence s_act;
      speed_inc_o || speed_dec_o || dec_stop_o || inst_stop_o;
   endsequence
   property p_bus_ack;
      s_req |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_rst_idle;
      disable iff (1'b0) rst_i |=> sync_fired_o == 4'h0 && gp_io_pin_oe_n_o == 4'hf;
   endproperty
   property p_fired_one;
      sync_fired_o != 4'h0 |-> $onehot(sync_fired_o);
   endproperty
   property p_set0_lat;
      sync_fired_o[0] |-> $past(activation_i[0], 2);
   endproperty
   property p_strobe_fired;
      s_act |-> sync_fired_o != 4'h0;
   endproperty
   property p_step_block;
      speed_inc_o || speed_dec_o |-> !$past(scurve_ramp_i) && !$past(interp_drive_i);
   endproperty
   property p_stop_excl;
      dec_stop_o |-> !inst_stop_o;
   endproperty

   a_bus_ack: assert property (p_bus_ack) else $error("ack missing");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_rst_idle: assert property (p_rst_idle) else $error("reset state wrong");
   a_fired_one: assert property (p_fired_one) else $error("two sets at once");
   a_set0_lat: assert property (p_set0_lat) else $error("set 0 latency");
   a_strobe_fired: assert property (p_strobe_fired) else $error("stray strobe");
   a_step_block: assert property (p_step_block) else $error("step not blocked");
   a_stop_excl: assert property (p_stop_excl) else $error("both stops");
endmodule

bind sae_top sae_props sae_props_i (.*);

// ===== sim/sae_top_tb_top.sv
`timescale 1ns/10ps
module sae_top_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0, activation_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, logical_position_counter_i = 32'h0;
   logic [31:0] real_position_counter_i = 32'h0, current_timer_value_i = 32'h0;
   logic [31:0] current_drive_speed_i = 32'h0, current_accel_value_i = 32'h0;
   logic        scurve_ramp_i = 1'b0, interp_drive_i = 1'b0;
   logic [31:0] wb_dat_o, drive_speed_o, drive_pulse_number_o, split_pulse_data1_o;
   logic [31:0] initial_speed_o, acceleration_value_o, speed_step_o, load_data_o;
   logic        wb_ack_o, lp_load_o, rp_load_o, start_rel_o, start_cnt_rel_o, start_abs_o;
   logic        start_pos_cont_o, start_neg_cont_o, dec_stop_o, inst_stop_o, speed_inc_o;
   logic        speed_dec_o, timer_start_o, timer_stop_o, split_start_o, split_end_o;
   logic [3:0]  sync_fired_o, gp_io_pin_o, gp_io_pin_oe_n_o;
   logic        lvl = 1'b0;
   int          err_total = 0, cmp_count = 0, cyc_n = 0, run_len = 0;
   int          tbl[8] = '{4, 8, 25, 100, 400, 1600, 40, 60};
   wire  [14:0] strb = {lp_load_o, rp_load_o, start_rel_o, start_cnt_rel_o, start_abs_o,
      start_pos_cont_o, start_neg_cont_o, dec_stop_o, inst_stop_o, speed_inc_o, speed_dec_o,
      timer_start_o, timer_stop_o, split_start_o, split_end_o};

   sae_top #(.PW6_CYC(40), .PW7_CYC(60)) sae_top_i (.*);

   always #20 clk_i = ~clk_i;
   always @(negedge clk_i) if (gp_io_pin_o[2] === lvl) run_len++;
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 30000) begin
         err_total++;
         results;
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task results;
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [14:0] ex(input logic [4:0] c);
      int p;
      p = (c == 5'h0f) ? 2 : (c == 5'h10) ? 4 : (c < 5'h0f) ? c - 8 : c - 10;
      return 15'h4000 >> p;
   endfunction
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      chk(wb_ack_o, 1'b1);
      q = wb_dat_o;
      @(posedge clk_i);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_sel_i <= 4'h0;
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task cmd(input logic [7:0] c, input logic [31:0] d);
      wr(8'h04, d);
      wr(8'h00, {24'h0, c});
   endtask
   task arm(input logic [1:0] k, input logic [4:0] c, input logic rep);
      cmd(8'h26 + {6'h0, k}, {16'h0, rep, 6'h0, c, 4'h0});
      cmd(8'h80 | (8'h01 << k), 32'h0);
   endtask
   task fire(input logic [3:0] m, input logic [3:0] w, output logic [14:0] s);
      int n;
      @(posedge clk_i);
      activation_i <= m;
      @(posedge clk_i);
      activation_i <= 4'h0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (sync_fired_o === 4'h0 && n < 10);
      chk(sync_fired_o, w);
      s = strb;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_loads;
      logic [14:0] s;
      logic [31:0] v;
      for (int k = 0; k < 4; k++) begin
         v = 32'h5a00_0000 + k;
         wr(8'h08 + 8'(4 * k), v);
         for (int c = 1; c < 5; c++) begin
            arm(2'(k), 5'(c), 1'b0);
            fire(4'h1 << k, 4'h1 << k, s);
         end
         chk(drive_speed_o, v);
         chk(drive_pulse_number_o, v);
         chk(split_pulse_data1_o, v);
         chk(s, k == 0 ? 15'h4000 : k == 1 ? 15'h2000 : 15'h0);
         if (k < 2) chk(load_data_o, v);
         if (k == 2) chk(initial_speed_o, v);
         if (k == 3) chk(acceleration_value_o, v);
      end
   endtask
   task t_saves;
      logic [14:0] s;
      logic [31:0] e;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         logical_position_counter_i <= 32'h0100_0000 + k;
         real_position_counter_i <= 32'h0200_0000 + k;
         current_timer_value_i <= 32'h0300_0000 + k;
         current_drive_speed_i <= 32'h0400_0000 + k;
         current_accel_value_i <= 32'h0500_0000 + k;
         for (int c = 5; c < 9; c++) begin
            arm(2'(k), 5'(c), 1'b0);
            fire(4'h1 << k, 4'h1 << k, s);
            e = (c == 8 && k > 1) ? 32'h0300_0000 + k : (c == 8 && k == 1) ?
               32'h0500_0000 + k : 32'h0100_0000 * (c - 4) + k;
            rd_chk(8'h08 + 8'(4 * k), e);
         end
      end
   endtask
   task t_codes;
      logic [14:0] s;
      logic [4:0]  ce;
      wr(8'h08, 32'h0000_1234);
      for (int c = 9; c < 25; c++) begin
         ce = (c == 9) ? 5'h00 : 5'(c);
         arm(2'd0, ce, 1'b0);
         fire(4'h1, 4'h1, s);
         chk(s, ce == 5'h00 ? 15'h0 : ex(ce));
      end
      chk(drive_pulse_number_o, 32'h1234);
      rd_chk(8'h1c, 32'h1234);
   endtask
   task t_step;
      logic [14:0] s;
      cmd(8'h15, 32'h0000_0077);
      chk(speed_step_o, 32'h77);
      @(posedge clk_i);
      scurve_ramp_i <= 1'b1;
      arm(2'd1, 5'h13, 1'b0);
      fire(4'h2, 4'h2, s);
      chk(s, 15'h0);
      @(posedge clk_i);
      scurve_ramp_i <= 1'b0;
      interp_drive_i <= 1'b1;
      arm(2'd1, 5'h14, 1'b0);
      fire(4'h2, 4'h2, s);
      chk(s, 15'h0);
      @(posedge clk_i);
      interp_drive_i <= 1'b0;
   endtask
   task t_order;
      logic [14:0] s;
      arm(2'd1, 5'h0a, 1'b0);
      arm(2'd2, 5'h11, 1'b0);
      fire(4'h6, 4'h2, s);
      chk(s, ex(5'h0a));
      @(posedge clk_i);
      #1;
      chk({sync_fired_o, strb}, {4'h4, ex(5'h11)});
      arm(2'd3, 5'h0a, 1'b1);
      cmd(8'h98, 32'h0);
      fire(4'h8, 4'h0, s);
      chk(s, 15'h0);
      cmd(8'h79, 32'h0);
      rd_chk(8'h2c, 32'h0);
   endtask
   task t_pin;
      logic [14:0] s;
      chk(gp_io_pin_oe_n_o, 4'hf);
      arm(2'd2, 5'h09, 1'b0);
      fire(4'h4, 4'h4, s);
      chk(gp_io_pin_o, 4'h0);
      cmd(8'h21, 32'h0000_0030);
      chk(gp_io_pin_oe_n_o, 4'hb);
      arm(2'd2, 5'h09, 1'b1);
      for (int w = 0; w < 8; w++) begin
         cmd(8'h22, {25'h0, 3'(w), 1'b0, w[0], 2'b0});
         lvl = ~w[0];
         run_len = 0;
         fire(4'h4, 4'h4, s);
         repeat (tbl[w] + 30) @(posedge clk_i);
         chk(run_len, tbl[w]);
      end
      run_len = 0;
      fire(4'h4, 4'h4, s);
      repeat (17) @(posedge clk_i);
      fire(4'h4, 4'h4, s);
      repeat (90) @(posedge clk_i);
      chk(run_len, 80);
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(gp_io_pin_oe_n_o, 4'hf);
      rd_chk(8'h2c, 32'h0);
      rd_chk(8'h44, 32'h0);
      t_loads;
      t_saves;
      t_codes;
      t_step;
      t_order;
      t_pin;
      results;
   end
endmodule
